// ===== core/rtc_cfg.svh
// register map, reset values and carrier constants for the tone mapper
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
`define RTC_REG_CTRL      12'h000
`define RTC_REG_ACE_EXT   12'h004
`define RTC_REG_ACE_CLIP  12'h008
`define RTC_REG_ACE_GAIN  12'h00C
`define RTC_REG_PATTERN   12'h010
`define RTC_REG_EXT_PHASE 12'h014
`define RTC_REG_P2_COUNT  12'h018
`define RTC_REG_DT_COUNT  12'h01C
`define RTC_REG_STATUS    12'h020
`define RTC_REG_P2_START  12'h024
`define RTC_REG_DT_START  12'h028
`define RTC_REG_CUR       12'h02C
`define RTC_TAB_P2_BASE   12'h400
`define RTC_TAB_DT_BASE   12'h900
`define RTC_TAB_SEL_HI    12'hD80
`define RTC_TAB_DEPTH     288
`define RTC_RST_DX        4'h3
`define RTC_RST_DY        4'h4
`define RTC_RST_COUNT     9'h048
`define RTC_RST_P2_START  15'h006A
`define RTC_RST_DT_START  15'h006F
`define RTC_P1_CENTRE     16'h01AA
`define RTC_KC_2K         16'h0354
`define RTC_KC_4K         16'h06A8
`define RTC_KC_8K         16'h0D50
`define RTC_KC_8K_EXT     16'h0D80
`define RTC_KC_16K        16'h1AA0
`define RTC_KC_16K_EXT    16'h1B30
`define RTC_KC_32K        16'h3540
`define RTC_KC_32K_EXT    16'h3660
`define RTC_KEXT_8K       15'h0030
`define RTC_KEXT_16K      15'h0090
`define RTC_KEXT_32K      15'h0120
`define RTC_RECIP_ONE     17'h10000
`endif

// ===== core/rtc_pkg.sv
// types shared by the reserved tone carrier mapper
package rtc_pkg;
  typedef enum logic [1:0] {
    RTC_P1   = 2'h0,
    RTC_P2   = 2'h1,
    RTC_DATA = 2'h3,
    RTC_FC   = 2'h2
  } rtc_kind_type;

  typedef enum logic [2:0] {
    RTC_1K = 3'h0, RTC_2K = 3'h1, RTC_4K = 3'h2,
    RTC_8K = 3'h3, RTC_16K = 3'h4, RTC_32K = 3'h5
  } rtc_fft_type;

  typedef enum logic {
    RTC_IDLE = 1'b0,
    RTC_MAP  = 1'b1
  } rtc_state_type;

  typedef struct packed {
    rtc_kind_type kind;
    logic [7:0]   index;
    rtc_fft_type  fft;
    logic [2:0]   pattern;
    logic         extended;
  } rtc_sym_type;

  typedef struct packed {
    logic [15:0] re;
    logic [15:0] im;
  } rtc_cell_type;
endpackage : rtc_pkg

// ===== core/rtc_mapper.sv
// reserved tone carrier mapper: zeroes reserved cells, maps IFFT bins
//
// Strobed register access and the placing of the registers were decided locally.
`include "rtc_cfg.svh"
module rtc_mapper
  import rtc_pkg::*;
(
  input  wire logic         clock,         // sample clock
  input  wire logic         rst,           // synchronous reset
  input  wire logic [11:0]  reg_addr,      // register byte address
  input  wire logic [31:0]  reg_wdata,     // register write data
  input  wire logic         reg_wr,        // write strobe
  input  wire logic         reg_rd,        // read strobe
  output logic      [31:0]  reg_rdata,     // read data, cycle after strobe
  input  wire logic         sym_start,     // first cell of a symbol follows
  input  wire rtc_sym_type  sym_info,      // symbol description
  input  wire logic         cell_valid,    // cell present
  input  wire logic [14:0]  cell_k,        // logical carrier index
  input  wire logic         cell_is_data,  // upstream meant a data cell
  input  wire rtc_cell_type cell_in,       // cell value
  output logic              out_valid,     // cell to IFFT
  output logic      [15:0]  out_bin,       // IFFT bin
  output rtc_cell_type      out_cell,      // cell value, zero if reserved
  output logic              out_reserved,  // cell is a reserved tone
  output logic              kernel_set_dt, // kernel built from data set
  output logic      [14:0]  kernel_start,  // first carrier of kernel set
  output logic      [16:0]  kernel_scale,  // 1/count, 16 fraction bits
  output logic      [3:0]   gain_exp,      // log2 of FFT size over 1K
  output logic              signal_field,  // peak-reduction field bit
  output logic              ace_enable,    // extension active
  output logic      [15:0]  ace_max_ext,   // maximum extension value
  output logic      [15:0]  ace_clip,      // clipping threshold
  output logic      [15:0]  ace_gain       // extension gain
);
  // offsets into the sorted tables, relative to the set start
  logic [14:0] tab_p2 [0:`RTC_TAB_DEPTH-1];
  logic [14:0] tab_dt [0:`RTC_TAB_DEPTH-1];
  logic          tr_enable;
  logic          ace_request;
  logic          rotated;
  logic [3:0]    pat_dx;
  logic [3:0]    pat_dy;
  logic [7:0]    ext_phase;
  logic [8:0]    p2_count;
  logic [8:0]    dt_count;
  logic [14:0]   p2_start;
  logic [14:0]   dt_start;
  logic          collision;
  rtc_state_type state;
  rtc_sym_type   cur;
  logic          reserving;
  logic [14:0]   set_start;
  logic [8:0]    set_count;
  logic          set_dt;
  logic [8:0]    ptr;
  logic [14:0]   entry;
  logic          hit;
  logic          wr_ok;

  function automatic logic [14:0] kext_of(rtc_fft_type f);
    case (f)
      RTC_8K:  kext_of = `RTC_KEXT_8K;
      RTC_16K: kext_of = `RTC_KEXT_16K;
      RTC_32K: kext_of = `RTC_KEXT_32K;
      default: kext_of = 15'h0000;
    endcase
  endfunction : kext_of

  // centre carrier per mode; extended grows both ends, so the centre moves up by the kext_of shift
  function automatic logic [15:0] centre_of(rtc_sym_type s);
    if (s.kind == RTC_P1) begin
      centre_of = `RTC_P1_CENTRE;
    end else begin
      case (s.fft)
        RTC_1K:  centre_of = `RTC_P1_CENTRE;
        RTC_2K:  centre_of = `RTC_KC_2K;
        RTC_4K:  centre_of = `RTC_KC_4K;
        RTC_8K:  centre_of = s.extended ? `RTC_KC_8K_EXT : `RTC_KC_8K;
        RTC_16K: centre_of = s.extended ? `RTC_KC_16K_EXT : `RTC_KC_16K;
        default: centre_of = s.extended ? `RTC_KC_32K_EXT : `RTC_KC_32K;
      endcase
    end
  endfunction : centre_of

  function automatic logic [3:0] log_of(rtc_sym_type s);
    log_of = (s.kind == RTC_P1) ? 4'h0 : {1'b0, s.fft};
  endfunction : log_of

  // bin = (k - centre) mod N; P1 always uses the 1K transform
  function automatic logic [15:0] bin_of(logic [14:0] k, rtc_sym_type s);
    logic [15:0] mask;
    mask   = (16'h0400 << log_of(s)) - 16'h0001;
    bin_of = ({1'b0, k} - centre_of(s)) & mask;
  endfunction : bin_of

  function automatic logic [14:0] shift_of(logic [7:0] idx, logic [7:0] ph,
                                           logic [3:0] dx, logic [3:0] dy);
    logic [8:0] pos;
    logic [3:0] sel;
    pos      = {1'b0, idx} + {1'b0, ph};
    sel      = (dy == 4'h0) ? 4'h0 : 4'((pos % {5'h00, dy}));
    shift_of = 15'(sel * dx);
  endfunction : shift_of

  function automatic logic [16:0] recip_of(logic [8:0] n);
    recip_of = (n == 9'h000) ? 17'h00000 : 17'(`RTC_RECIP_ONE / n);
  endfunction : recip_of

  assign wr_ok = reg_wr && !reg_rd;
  // control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      tr_enable   <= 1'b0;
      ace_request <= 1'b0;
      rotated     <= 1'b0;
      ace_max_ext <= 16'h0000;
      ace_clip    <= 16'h0000;
      ace_gain    <= 16'h0000;
      pat_dx      <= `RTC_RST_DX;
      pat_dy      <= `RTC_RST_DY;
      ext_phase   <= 8'h00;
      p2_count    <= `RTC_RST_COUNT;
      dt_count    <= `RTC_RST_COUNT;
      p2_start    <= `RTC_RST_P2_START;
      dt_start    <= `RTC_RST_DT_START;
    end else if (wr_ok) begin
      if (reg_addr == `RTC_REG_CTRL) begin
        tr_enable   <= reg_wdata[0];
        ace_request <= reg_wdata[1];
        rotated     <= reg_wdata[2];
      end else if (reg_addr == `RTC_REG_ACE_EXT) begin
        ace_max_ext <= reg_wdata[15:0];
      end else if (reg_addr == `RTC_REG_ACE_CLIP) begin
        ace_clip <= reg_wdata[15:0];
      end else if (reg_addr == `RTC_REG_ACE_GAIN) begin
        ace_gain <= reg_wdata[15:0];
      end else if (reg_addr == `RTC_REG_PATTERN) begin
        pat_dx <= reg_wdata[3:0];
        pat_dy <= reg_wdata[7:4];
      end else if (reg_addr == `RTC_REG_EXT_PHASE) begin
        ext_phase <= reg_wdata[7:0];
      end else if (reg_addr == `RTC_REG_P2_COUNT) begin
        p2_count <= reg_wdata[8:0];
      end else if (reg_addr == `RTC_REG_DT_COUNT) begin
        dt_count <= reg_wdata[8:0];
      end else if (reg_addr == `RTC_REG_P2_START) begin
        p2_start <= reg_wdata[14:0];
      end else if (reg_addr == `RTC_REG_DT_START) begin
        dt_start <= reg_wdata[14:0];
      end
    end
  end

  // offset tables, one word per entry
  always_ff @(posedge clock) begin
    if (wr_ok && reg_addr >= `RTC_TAB_P2_BASE &&
        reg_addr < `RTC_TAB_DT_BASE &&
        reg_addr[11:2] - `RTC_TAB_P2_BASE / 4 < 10'(`RTC_TAB_DEPTH)) begin
      tab_p2[9'(reg_addr[11:2] - `RTC_TAB_P2_BASE / 4)] <= reg_wdata[14:0];
    end
    if (wr_ok && reg_addr >= `RTC_TAB_DT_BASE &&
        reg_addr < `RTC_TAB_SEL_HI &&
        reg_addr[11:2] - `RTC_TAB_DT_BASE / 4 < 10'(`RTC_TAB_DEPTH)) begin
      tab_dt[9'(reg_addr[11:2] - `RTC_TAB_DT_BASE / 4)] <= reg_wdata[14:0];
    end
  end

  // read port; tables are write-only and read as zero
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == `RTC_REG_CTRL) begin
        reg_rdata <= {29'h0, rotated, ace_request, tr_enable};
      end else if (reg_addr == `RTC_REG_ACE_EXT) begin
        reg_rdata <= {16'h0000, ace_max_ext};
      end else if (reg_addr == `RTC_REG_ACE_CLIP) begin
        reg_rdata <= {16'h0000, ace_clip};
      end else if (reg_addr == `RTC_REG_ACE_GAIN) begin
        reg_rdata <= {16'h0000, ace_gain};
      end else if (reg_addr == `RTC_REG_PATTERN) begin
        reg_rdata <= {24'h000000, pat_dy, pat_dx};
      end else if (reg_addr == `RTC_REG_EXT_PHASE) begin
        reg_rdata <= {24'h000000, ext_phase};
      end else if (reg_addr == `RTC_REG_P2_COUNT) begin
        reg_rdata <= {23'h000000, p2_count};
      end else if (reg_addr == `RTC_REG_DT_COUNT) begin
        reg_rdata <= {23'h000000, dt_count};
      end else if (reg_addr == `RTC_REG_STATUS) begin
        reg_rdata <= {29'h0, reserving, state, collision};
      end else if (reg_addr == `RTC_REG_P2_START) begin
        reg_rdata <= {17'h00000, p2_start};
      end else if (reg_addr == `RTC_REG_DT_START) begin
        reg_rdata <= {17'h00000, dt_start};
      end else if (reg_addr == `RTC_REG_CUR) begin
        reg_rdata <= {8'h00, ptr[7:0], set_dt, set_start};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  assign ace_enable   = ace_request && !rotated;
  assign signal_field = tr_enable;

  // per-symbol set choice, latched at symbol start
  always_ff @(posedge clock) begin
    if (rst) begin
      state     <= RTC_IDLE;
      cur       <= '0;
      reserving <= 1'b0;
      set_start <= 15'h0000;
      set_count <= 9'h000;
      set_dt    <= 1'b0;
    end else if (sym_start) begin
      state <= RTC_MAP;
      cur   <= sym_info;
      case (sym_info.kind)
        RTC_P1: begin
          reserving <= 1'b0;
          set_dt    <= 1'b0;
          set_start <= 15'h0000;
          set_count <= 9'h000;
        end
        RTC_P2, RTC_FC: begin
          // P2 always reserves, frame closing only when enabled
          reserving <= (sym_info.kind == RTC_P2) || tr_enable;
          set_dt    <= 1'b0;
          set_count <= p2_count;
          set_start <= p2_start + (sym_info.extended ?
                       kext_of(sym_info.fft) : 15'h0000);
        end
        default: begin
          reserving <= tr_enable;
          set_dt    <= 1'b1;
          set_count <= dt_count;
          // step with the scattered pilots; phase adjusts in extended mode
          set_start <= dt_start + (sym_info.extended ?
                       kext_of(sym_info.fft) : 15'h0000) +
                       shift_of(sym_info.index,
                                sym_info.extended ? ext_phase : 8'h00,
                                pat_dx, pat_dy);
        end
      endcase
    end
  end

  assign entry = set_dt ? tab_dt[ptr] : tab_p2[ptr];
  // cells arrive in ascending carrier order, so one pointer walks the set
  assign hit = reserving && (ptr < set_count) &&
               (cell_k == set_start + entry);

  always_ff @(posedge clock) begin
    if (rst || sym_start) begin
      ptr <= 9'h000;
    end else if (state == RTC_MAP && cell_valid && hit) begin
      ptr <= ptr + 9'h001;
    end
  end

  // output stage; reserved cells are zero and flagged for the canceller
  always_ff @(posedge clock) begin
    if (rst) begin
      out_valid    <= 1'b0;
      out_bin      <= 16'h0000;
      out_cell     <= '0;
      out_reserved <= 1'b0;
    end else begin
      out_valid    <= cell_valid && state == RTC_MAP && !sym_start;
      out_bin      <= bin_of(cell_k, cur);
      out_cell     <= hit ? '0 : cell_in;
      out_reserved <= hit;
    end
  end

  // kernel description for the canceller, fixed for the symbol
  always_ff @(posedge clock) begin
    if (rst) begin
      kernel_set_dt <= 1'b0;
      kernel_start  <= 15'h0000;
      kernel_scale  <= 17'h00000;
      gain_exp      <= 4'h0;
    end else begin
      kernel_set_dt <= set_dt;
      kernel_start  <= set_start;
      kernel_scale  <= reserving ? recip_of(set_count) : '0;
      gain_exp      <= log_of(cur);
    end
  end

  // a data cell on a reserved carrier is dropped and latched; set wins
  always_ff @(posedge clock) begin
    if (rst) begin
      collision <= 1'b0;
    end else if (state == RTC_MAP && cell_valid && hit && cell_is_data) begin
      collision <= 1'b1;
    end else if (wr_ok && reg_addr == `RTC_REG_STATUS && reg_wdata[0]) begin
      collision <= 1'b0;
    end
  end

  sequence s_res_cell;
    cell_valid && state == RTC_MAP && !sym_start && hit;
  endsequence

  property p_zero_reserved;
    @(posedge clock) disable iff (rst)
      s_res_cell |=> out_valid && out_reserved && out_cell == '0;
  endproperty
  a_zero_reserved: assert property (p_zero_reserved)
    else $error("reserved cell not zeroed");

  property p_p1_centre;
    @(posedge clock) disable iff (rst)
      cell_valid && state == RTC_MAP && cur.kind == RTC_P1 &&
      cell_k == 15'(`RTC_P1_CENTRE) |=> out_bin == 16'h0000;
  endproperty
  a_p1_centre: assert property (p_p1_centre)
    else $error("P1 centre carrier off bin zero");

  property p_no_p1_res;
    @(posedge clock) disable iff (rst)
      sym_start && sym_info.kind == RTC_P1 |=> !reserving;
  endproperty
  a_no_p1_res: assert property (p_no_p1_res)
    else $error("P1 symbol reserving tones");

  property p_p2_always;
    @(posedge clock) disable iff (rst)
      sym_start && sym_info.kind == RTC_P2 |=> reserving && !set_dt;
  endproperty
  a_p2_always: assert property (p_p2_always)
    else $error("P2 symbol without reserved set");

  property p_field_gate;
    @(posedge clock) disable iff (rst)
      sym_start && sym_info.kind == RTC_DATA |=>
      reserving == $past(tr_enable);
  endproperty
  a_field_gate: assert property (p_field_gate)
    else $error("data reservation not following field");

  property p_fc_set;
    @(posedge clock) disable iff (rst)
      sym_start && sym_info.kind == RTC_FC && !sym_info.extended |=>
      set_start == $past(p2_start) && !set_dt;
  endproperty
  a_fc_set: assert property (p_fc_set)
    else $error("frame-closing set differs from P2 set");

  property p_ace_off;
    @(posedge clock) disable iff (rst) rotated |-> !ace_enable;
  endproperty
  a_ace_off: assert property (p_ace_off)
    else $error("extension active with rotation");

  sequence s_kernel_follow;
    ##1 kernel_start == $past(set_start) && kernel_set_dt == $past(set_dt);
  endsequence

  property p_kernel;
    @(posedge clock) disable iff (rst) sym_start |=> s_kernel_follow;
  endproperty
  a_kernel: assert property (p_kernel)
    else $error("kernel not matched to symbol set");

  property p_ptr_bound;
    @(posedge clock) disable iff (rst) ptr <= set_count || sym_start;
  endproperty
  a_ptr_bound: assert property (p_ptr_bound)
    else $error("set pointer ran past count");

  property p_coll_set;
    @(posedge clock) disable iff (rst)
      s_res_cell |=> collision || !$past(cell_is_data);
  endproperty
  a_coll_set: assert property (p_coll_set)
    else $error("collision not latched");
endmodule : rtc_mapper

// ===== test/rtc_feed.sv
// upstream frame builder model: symbol header, then 16 ascending cells
module rtc_feed
  import rtc_pkg::*;
(
  input  wire logic        clock,        // sample clock
  input  wire logic        go,           // start one symbol
  input  wire rtc_sym_type info,         // symbol to announce
  input  wire logic [14:0] k_lo,         // first carrier of the run
  output logic             busy,         // symbol in progress
  output logic             sym_start    = 1'b0,     // header pulse
  output rtc_sym_type      sym_info     = '0,       // header
  output logic             cell_valid   = 1'b0,     // cell present
  output logic      [14:0] cell_k       = 15'h0000, // carrier index
  output logic             cell_is_data = 1'b0,     // offered as data cell
  output rtc_cell_type     cell_in      = '0        // cell value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        active = 1'b0;
  logic [14:0] k      = 15'h0000;
  assign busy = active | sym_start;
  // header with type, index, size and mode, then one cell per cycle
  always @(posedge clock) begin
    sym_start <= go;
    if (go) begin
      sym_info <= info;
      k        <= k_lo;
      active   <= 1'b1;
    end
    if (active) begin
      cell_valid   <= 1'b1;
      cell_k       <= k;
      cell_is_data <= 1'b1;
      cell_in      <= {1'b0, k, 16'h5A5A};
      active       <= (k != k_lo + 15'h000F);
      k            <= k + 15'h0001;
    end else begin
      // released lines toggle so stale values never look valid
      cell_valid   <= 1'b0;
      cell_k       <= ~cell_k;
      cell_is_data <= ~cell_is_data;
      cell_in      <= ~cell_in;
    end
  end
endmodule : rtc_feed

// ===== test/rtc_mapper_tb_top.sv
// self-checking bench for the reserved tone carrier mapper
`include "rtc_cfg.svh"
module rtc_mapper_tb_top
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clock     = 1'b0;
  logic         rst       = 1'b1;
  logic [11:0]  reg_addr  = 12'h000;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_wr    = 1'b0;
  logic         reg_rd    = 1'b0;
  logic         go        = 1'b0;
  rtc_sym_type  info      = '0;
  logic [14:0]  k_lo      = 15'h0000;
  logic [31:0]  reg_rdata;
  logic         busy, sym_start, cell_valid, cell_is_data, out_valid;
  logic         out_reserved, kernel_set_dt, signal_field, ace_enable;
  rtc_sym_type  sym_info;
  logic [14:0]  cell_k, kernel_start;
  rtc_cell_type cell_in, out_cell;
  logic [15:0]  out_bin, ace_max_ext, ace_clip, ace_gain;
  logic [16:0]  kernel_scale;
  logic [3:0]   gain_exp;
  logic [48:0]  seen[$];
  int           n_errors  = 0;
  int           cmp_count = 0;

  always #2 clock = ~clock;

  rtc_mapper u_dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sym_start, .sym_info, .cell_valid, .cell_k, .cell_is_data,
    .cell_in, .out_valid, .out_bin, .out_cell, .out_reserved, .kernel_set_dt,
    .kernel_start, .kernel_scale, .gain_exp, .signal_field, .ace_enable,
    .ace_max_ext, .ace_clip, .ace_gain);
  rtc_feed u_feed (.clock, .go, .info, .k_lo, .busy, .sym_start, .sym_info,
    .cell_valid, .cell_k, .cell_is_data, .cell_in);

  always @(posedge clock) begin
    if (out_valid === 1'b1) begin
      seen.push_back({out_reserved, out_bin, out_cell});
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 check("read data", exp, reg_rdata);
    @(posedge clock);
  endtask : rd

  // 16 cells from lo; P2 offsets {0,3,4}, data offsets {0,4} from start
  task automatic run_sym(input rtc_kind_type kd, input logic [7:0] idx,
                         input logic ext, input int lo, input logic rsv,
                         input logic dt, input int start);
    int          kc;
    int          nb;
    int          k;
    logic        hit;
    logic [48:0] e;
    kc = (kd == RTC_P1) ? 426 : (ext ? 3456 : 3408);
    nb = (kd == RTC_P1) ? 1024 : 8192;
    info <= '{kind: kd, index: idx, fft: RTC_8K, pattern: 3'h1,
              extended: ext};
    k_lo <= 15'(lo);
    go   <= 1'b1;
    @(posedge clock);
    go   <= 1'b0;
    #1;
    for (int i = 0; i < 60 && busy === 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    repeat (3) @(posedge clock);
    check("cell count", 32'h10, 32'(seen.size()));
    for (int i = 0; i < 16 && i < seen.size(); i++) begin
      k   = lo + i;
      hit = rsv && (k == start || k == start + 4 || (!dt && k == start + 3));
      e   = {hit, 16'((k - kc + nb) % nb),
             hit ? 32'h0 : {1'b0, 15'(k), 16'h5A5A}};
      check("out cell", e[31:0], seen[i][31:0]);
      check("out bin", 32'(e[47:32]), 32'(seen[i][47:32]));
      check("reserved flag", 32'(e[48]), 32'(seen[i][48]));
    end
    seen.delete();
    check("gain exponent", (kd == RTC_P1) ? 32'h0 : 32'h3,
          32'(gain_exp));
    check("kernel scale", rsv ? (dt ? 32'h8000 : 32'h5555) : 32'h0,
          32'(kernel_scale));
    if (rsv) begin
      check("kernel start", 32'(start), 32'(kernel_start));
      check("kernel set", 32'(dt), 32'(kernel_set_dt));
    end
  endtask : run_sym

  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(`RTC_REG_PATTERN, 32'h43);
    rd(`RTC_REG_P2_COUNT, 32'h48);
    rd(`RTC_REG_P2_START, 32'h6A);
    rd(`RTC_REG_DT_START, 32'h6F);
    rd(12'h100, 32'h0);
    // short sets keep the kernel scale easy to predict
    wr(`RTC_REG_P2_COUNT, 32'h3);
    wr(`RTC_REG_DT_COUNT, 32'h2);
    wr(`RTC_TAB_P2_BASE, 32'h0);
    wr(`RTC_TAB_P2_BASE + 12'h004, 32'h3);
    wr(`RTC_TAB_P2_BASE + 12'h008, 32'h4);
    wr(`RTC_TAB_DT_BASE, 32'h0);
    wr(`RTC_TAB_DT_BASE + 12'h004, 32'h4);
    run_sym(RTC_P1, 8'h00, 1'b0, 418, 1'b0, 1'b0, 0);
    run_sym(RTC_P2, 8'h00, 1'b0, 104, 1'b1, 1'b0, 106);
    run_sym(RTC_P2, 8'h01, 1'b0, 104, 1'b1, 1'b0, 106);
    run_sym(RTC_DATA, 8'h02, 1'b0, 110, 1'b0, 1'b0, 0);
    run_sym(RTC_FC, 8'h03, 1'b0, 104, 1'b0, 1'b0, 0);
    wr(`RTC_REG_CTRL, 32'h1);
    for (int i = 0; i < 5; i++) begin
      // sets step 111, 114, 117, 120 and wrap with the pilot pattern
      run_sym(RTC_DATA, 8'(i), 1'b0, 110, 1'b1, 1'b1,
              111 + 3 * (i % 4));
    end
    run_sym(RTC_FC, 8'h05, 1'b0, 104, 1'b1, 1'b0, 106);
    wr(`RTC_REG_EXT_PHASE, 32'h1);
    run_sym(RTC_P2, 8'h00, 1'b1, 150, 1'b1, 1'b0, 154);
    run_sym(RTC_P2, 8'h01, 1'b1, 3450, 1'b1, 1'b0, 154);
    // 111 + 48 offset + ((2 + phase 1) mod 4) * 3
    run_sym(RTC_DATA, 8'h02, 1'b1, 158, 1'b1, 1'b1, 168);
    run_sym(RTC_FC, 8'h03, 1'b1, 150, 1'b1, 1'b0, 154);
    // every offered cell was marked data, so a collision is latched
    rd(`RTC_REG_STATUS, 32'h7);
    rd(`RTC_REG_CUR, 32'h0003009A);
    wr(`RTC_REG_STATUS, 32'h1);
    rd(`RTC_REG_STATUS, 32'h6);
    wr(`RTC_REG_ACE_EXT, 32'h1234);
    wr(`RTC_REG_ACE_CLIP, 32'h0456);
    wr(`RTC_REG_ACE_GAIN, 32'h0789);
    check("max extension", 32'h1234, 32'(ace_max_ext));
    check("clip threshold", 32'h0456, 32'(ace_clip));
    check("extension gain", 32'h0789, 32'(ace_gain));
    for (int c = 0; c < 8; c++) begin
      wr(`RTC_REG_CTRL, 32'(c));
      check("field bit", 32'(c & 1), 32'(signal_field));
      check("extension on", 32'((c >> 1) & ~(c >> 2) & 1),
            32'(ace_enable));
    end
    complete_run();
  end
endmodule : rtc_mapper_tb_top
